// >>> cbt_pkg.sv
package cbt_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 20;

    // register map, byte addresses inside the slave window
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_BIT_TIMING = 12'h000;
    localparam logic [11:0] OFS_RX_FLAGS = 12'h004;
    localparam logic [11:0] OFS_RX_IRQ_EN = 12'h008;
    localparam logic [11:0] OFS_MODE_STATUS = 12'h00C;

    // bit_timing_segments fields
    localparam int TRIPLE_BIT = 7;
    localparam int SEG2_MSB = 6;
    localparam int SEG2_LSB = 4;
    localparam int SEG1_MSB = 3;
    localparam int SEG1_LSB = 0;
    localparam logic [7:0] BIT_TIMING_RESET = 8'h00;
    localparam logic [2:0] SEG2_MIN_CODE = 3'h1;
    localparam logic [3:0] SEG1_MIN_CODE = 4'h3;

    // receiver_flags and receiver_irq_enables fields
    localparam int WAKE_BIT = 7;
    localparam int CSC_BIT = 6;
    localparam int RXST_MSB = 5;
    localparam int RXST_LSB = 4;
    localparam int TXST_MSB = 3;
    localparam int TXST_LSB = 2;
    localparam int OVR_BIT = 1;
    localparam int RXF_BIT = 0;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] IRQ_EN_RESET = 4'h0;

    // mode_status fields
    localparam int STAT_INIT_BIT = 0;
    localparam int STAT_SEG_BAD_BIT = 1;

    // error counter limits
    localparam logic [8:0] WARN_LIMIT = 9'h060;
    localparam logic [8:0] PASSIVE_LIMIT = 9'h07F;
    localparam logic [8:0] BUSOFF_LIMIT = 9'h0FF;

    // bit timing
    localparam int TQ_IDX_W = 5;
    localparam int PRESC_W = 6;

    // ahb-lite
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        ERR_OK = 2'h0,
        ERR_WARN = 2'h1,
        ERR_PASSIVE = 2'h2,
        ERR_BUSOFF = 2'h3
    } cbt_err_type;

    typedef enum logic {
        AHB_IDLE = 1'b0,
        AHB_READ_WAIT = 1'b1
    } cbt_ahb_type;
endpackage : cbt_pkg

// >>> cbt_err_state.sv
`timescale 1ns/1ps
module cbt_err_state (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // error counters
    input wire logic [8:0] tx_count,
    input wire logic [7:0] rx_count,
    // live states
    output cbt_pkg::cbt_err_type rx_state_q,
    output cbt_pkg::cbt_err_type tx_state_q
);
    wire logic bus_off = tx_count > cbt_pkg::BUSOFF_LIMIT;
    wire logic [8:0] rx_wide = {1'b0, rx_count};
    cbt_pkg::cbt_err_type rx_d;
    cbt_pkg::cbt_err_type tx_d;

    // bus-off overrides the receiver state as well
    assign rx_d = cbt_pkg::cbt_err_type'(bus_off ? cbt_pkg::ERR_BUSOFF :
        (rx_wide > cbt_pkg::PASSIVE_LIMIT) ? cbt_pkg::ERR_PASSIVE :
        (rx_wide > cbt_pkg::WARN_LIMIT) ? cbt_pkg::ERR_WARN : cbt_pkg::ERR_OK);
    assign tx_d = cbt_pkg::cbt_err_type'(bus_off ? cbt_pkg::ERR_BUSOFF :
        (tx_count > cbt_pkg::PASSIVE_LIMIT) ? cbt_pkg::ERR_PASSIVE :
        (tx_count > cbt_pkg::WARN_LIMIT) ? cbt_pkg::ERR_WARN : cbt_pkg::ERR_OK);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_q <= cbt_pkg::ERR_OK;
            tx_state_q <= cbt_pkg::ERR_OK;
        end else begin
            rx_state_q <= rx_d;
            tx_state_q <= tx_d;
        end
    end

    property p_busoff_rx;
        @(posedge clk) disable iff (!rst_n)
        (tx_count > cbt_pkg::BUSOFF_LIMIT) |=> (rx_state_q == cbt_pkg::ERR_BUSOFF);
    endproperty
    a_busoff_rx: assert property (p_busoff_rx) else $error("rx state not bus-off");

    property p_rx_warn;
        @(posedge clk) disable iff (!rst_n)
        (tx_count <= cbt_pkg::BUSOFF_LIMIT && rx_count > 8'h60 && rx_count <= 8'h7F)
            |=> (rx_state_q == cbt_pkg::ERR_WARN);
    endproperty
    a_rx_warn: assert property (p_rx_warn) else $error("rx warning state wrong");

    property p_tx_passive;
        @(posedge clk) disable iff (!rst_n)
        (tx_count > 9'h07F && tx_count <= 9'h0FF) |=> (tx_state_q == cbt_pkg::ERR_PASSIVE);
    endproperty
    a_tx_passive: assert property (p_tx_passive) else $error("tx passive state wrong");
endmodule : cbt_err_state

// >>> cbt_bit_timer.sv
`timescale 1ns/1ps
module cbt_bit_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic run,
    input wire logic [5:0] prescaler,
    input wire logic [3:0] seg1,
    input wire logic [2:0] seg2,
    input wire logic triple,
    // filtered bus level
    input wire logic rx,
    // results
    output logic tq_tick_q,
    output logic bit_q,
    output logic bit_valid_q
);
    localparam int IW = cbt_pkg::TQ_IDX_W;
    logic [5:0] presc_cnt_q;
    logic [IW-1:0] idx_q;
    logic [1:0] early_q;
    wire logic tick = run && (presc_cnt_q == prescaler);
    // sync quantum is index 0, then seg1+1 quanta, then seg2+1 quanta
    wire logic [IW-1:0] triple_sample_sel_idx = IW'(seg1) + IW'(1);
    wire logic [IW-1:0] last_idx = IW'(seg1) + IW'(seg2) + IW'(2);
    wire logic at_triple_sample_sel = tick && (idx_q == triple_sample_sel_idx);
    wire logic majority = (early_q[0] & early_q[1]) | (early_q[0] & rx) | (early_q[1] & rx);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_cnt_q <= 6'h00;
        end else if (!run || tick) begin
            presc_cnt_q <= 6'h00;
        end else begin
            presc_cnt_q <= presc_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= '0;
        end else if (!run) begin
            idx_q <= '0;
        end else if (tick) begin
            idx_q <= (idx_q >= last_idx) ? '0 : idx_q + IW'(1);
        end
    end

    // the two extra samples sit in the last quanta before the sample point
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            early_q <= 2'h0;
        end else if (tick && idx_q == triple_sample_sel_idx - IW'(2)) begin
            early_q[0] <= rx;
        end else if (tick && idx_q == triple_sample_sel_idx - IW'(1)) begin
            early_q[1] <= rx;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tq_tick_q <= 1'b0;
            bit_q <= 1'b1;
            bit_valid_q <= 1'b0;
        end else begin
            tq_tick_q <= tick;
            bit_valid_q <= at_triple_sample_sel;
            if (at_triple_sample_sel) begin
                bit_q <= triple ? majority : rx;
            end
        end
    end

    // helper counters for period checks
    logic [6:0] since_tick_q;
    logic [IW:0] quanta_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            since_tick_q <= 7'h00;
            quanta_q <= '0;
        end else begin
            since_tick_q <= (!run || tick) ? 7'h00 : since_tick_q + 7'h01;
            if (!run || (tick && idx_q >= last_idx)) begin
                quanta_q <= '0;
            end else if (tick) begin
                quanta_q <= quanta_q + (IW+1)'(1);
            end
        end
    end

    property p_tick_period;
        @(posedge clk) disable iff (!rst_n)
        tick |-> (since_tick_q == {1'b0, prescaler});
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("quantum period wrong");

    property p_bit_quanta;
        @(posedge clk) disable iff (!rst_n)
        (tick && idx_q == last_idx) |-> (quanta_q == (IW+1)'(seg1) + (IW+1)'(seg2) + (IW+1)'(2));
    endproperty
    a_bit_quanta: assert property (p_bit_quanta) else $error("bit length wrong");

    property p_single_sample;
        @(posedge clk) disable iff (!rst_n)
        (at_triple_sample_sel && !triple) |=> (bit_valid_q && bit_q == $past(rx));
    endproperty
    a_single_sample: assert property (p_single_sample) else $error("single sample wrong");

    property p_triple_sample;
        @(posedge clk) disable iff (!rst_n)
        (at_triple_sample_sel && triple && early_q == 2'h3) |=> bit_q;
    endproperty
    a_triple_sample: assert property (p_triple_sample) else $error("majority wrong");
endmodule : cbt_bit_timer

// >>> cbt_top.sv
// The AHB-Lite register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module cbt_top (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // controller side
    input wire logic INIT_REQUEST,
    input wire logic INIT_ACK,
    input wire logic SLEEP_ACTIVE,
    input wire logic WAKEUP_ENABLE,
    input wire logic [5:0] PRESCALER,
    input wire logic [8:0] TX_ERROR_COUNT,
    input wire logic [7:0] RX_ERROR_COUNT,
    input wire logic OVERRUN_EVENT,
    input wire logic RX_MSG_SHIFTED,
    // can bus
    input wire logic CAN_RX,
    // bit timing results
    output logic TQ_TICK,
    output logic RX_BIT,
    output logic RX_BIT_VALID,
    output logic SEG_CFG_INVALID,
    // interrupts and fifo gate
    output logic WAKEUP_IRQ,
    output logic ERROR_IRQ,
    output logic RX_IRQ,
    output logic FIFO_ADVANCE_OK
);
    // flag vector order: wake, status change, overrun, receive full
    localparam int F_WAKE = 3;
    localparam int F_CSC = 2;
    localparam int F_OVR = 1;
    localparam int F_RXF = 0;

    // bus pin synchroniser
    logic [2:0] rx_sync_q;
    logic rx_level_q;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rx_sync_q <= 3'h7;
            rx_level_q <= 1'b1;
        end else begin
            rx_sync_q <= {rx_sync_q[1:0], CAN_RX};
            if (rx_sync_q[1] == rx_sync_q[2]) begin
                rx_level_q <= rx_sync_q[2];
            end
        end
    end

    wire logic init_mode = INIT_REQUEST && INIT_ACK;
    wire logic run_mode = !INIT_REQUEST && !INIT_ACK;

    // ahb-lite slave: writes have no wait state, reads one
    cbt_pkg::cbt_ahb_type ahb_q;
    logic wr_pend_q;
    logic [11:0] addr_q;
    logic hready_q;
    logic [31:0] hrdata_q;
    wire logic take = HSEL && HTRANS == cbt_pkg::HTRANS_NONSEQ && HREADY;
    wire logic hit_btr = addr_q == cbt_pkg::OFS_BIT_TIMING;
    wire logic hit_flg = addr_q == cbt_pkg::OFS_RX_FLAGS;
    wire logic hit_ien = addr_q == cbt_pkg::OFS_RX_IRQ_EN;
    wire logic hit_sts = addr_q == cbt_pkg::OFS_MODE_STATUS;

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ahb_q <= cbt_pkg::AHB_IDLE;
            wr_pend_q <= 1'b0;
            addr_q <= 12'h000;
            hready_q <= 1'b1;
        end else begin
            case (ahb_q)
                cbt_pkg::AHB_IDLE: begin
                    wr_pend_q <= take && HWRITE;
                    if (take) begin
                        addr_q <= HADDR[11:0];
                    end
                    if (take && !HWRITE) begin
                        ahb_q <= cbt_pkg::AHB_READ_WAIT;
                        hready_q <= 1'b0;
                    end
                end
                cbt_pkg::AHB_READ_WAIT: begin
                    ahb_q <= cbt_pkg::AHB_IDLE;
                    hready_q <= 1'b1;
                end
                default: begin
                    ahb_q <= cbt_pkg::AHB_IDLE;
                    hready_q <= 1'b1;
                    wr_pend_q <= 1'b0;
                end
            endcase
        end
    end

    // bit_timing_segments
    logic [7:0] btr_q;
    wire logic wr_btr = wr_pend_q && hit_btr && init_mode;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            btr_q <= cbt_pkg::BIT_TIMING_RESET;
        end else if (wr_btr) begin
            btr_q <= HWDATA[7:0];
        end
    end
    wire logic [3:0] seg1 = btr_q[cbt_pkg::SEG1_MSB:cbt_pkg::SEG1_LSB];
    wire logic [2:0] seg2 = btr_q[cbt_pkg::SEG2_MSB:cbt_pkg::SEG2_LSB];
    wire logic seg_bad = seg2 < cbt_pkg::SEG2_MIN_CODE || seg1 < cbt_pkg::SEG1_MIN_CODE;

    cbt_bit_timer u_timer (
        .clk(CLOCK),
        .rst_n(RST_B),
        .run(!init_mode),
        .prescaler(PRESCALER),
        .seg1(seg1),
        .seg2(seg2),
        .triple(btr_q[cbt_pkg::TRIPLE_BIT]),
        .rx(rx_level_q),
        .tq_tick_q(TQ_TICK),
        .bit_q(RX_BIT),
        .bit_valid_q(RX_BIT_VALID)
    );

    // counter-derived bus state, shown copy frozen while status change pends
    cbt_pkg::cbt_err_type rx_live;
    cbt_pkg::cbt_err_type tx_live;
    cbt_pkg::cbt_err_type rx_prev_q;
    cbt_pkg::cbt_err_type tx_prev_q;
    cbt_pkg::cbt_err_type rx_shown_q;
    cbt_pkg::cbt_err_type tx_shown_q;

    cbt_err_state u_err (
        .clk(CLOCK),
        .rst_n(RST_B),
        .tx_count(TX_ERROR_COUNT),
        .rx_count(RX_ERROR_COUNT),
        .rx_state_q(rx_live),
        .tx_state_q(tx_live)
    );

    logic [3:0] flag_q;
    wire logic live_chg = rx_live != rx_prev_q || tx_live != tx_prev_q;
    wire logic shown_stale = rx_live != rx_shown_q || tx_live != tx_shown_q;

    // init does not touch the shown state; it tracks because the flag is held clear
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            rx_prev_q <= cbt_pkg::ERR_OK;
            tx_prev_q <= cbt_pkg::ERR_OK;
            rx_shown_q <= cbt_pkg::ERR_OK;
            tx_shown_q <= cbt_pkg::ERR_OK;
        end else begin
            rx_prev_q <= rx_live;
            tx_prev_q <= tx_live;
            if (!flag_q[F_CSC]) begin
                rx_shown_q <= rx_live;
                tx_shown_q <= tx_live;
            end
        end
    end

    // receiver_flags: set wins over clear, set term also blocks the clear
    wire logic wr_flg = wr_pend_q && hit_flg && run_mode;
    wire logic [3:0] flag_set;
    wire logic [3:0] flag_clr;
    assign flag_set[F_WAKE] = SLEEP_ACTIVE && WAKEUP_ENABLE && !rx_level_q;
    // while pending only a fresh change holds it, so the clear is not blocked forever
    assign flag_set[F_CSC] = flag_q[F_CSC] ? live_chg : shown_stale;
    assign flag_set[F_OVR] = OVERRUN_EVENT;
    assign flag_set[F_RXF] = RX_MSG_SHIFTED;
    assign flag_clr = wr_flg ? {HWDATA[cbt_pkg::WAKE_BIT], HWDATA[cbt_pkg::CSC_BIT],
        HWDATA[cbt_pkg::OVR_BIT], HWDATA[cbt_pkg::RXF_BIT]} : 4'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_flag
            always_ff @(posedge CLOCK or negedge RST_B) begin
                if (!RST_B) begin
                    flag_q[gi] <= cbt_pkg::FLAGS_RESET[gi];
                end else if (init_mode) begin
                    flag_q[gi] <= cbt_pkg::FLAGS_RESET[gi];
                end else if (flag_set[gi]) begin
                    flag_q[gi] <= 1'b1;
                end else if (flag_clr[gi]) begin
                    flag_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // receiver_irq_enables, same bit order as the flags
    logic [3:0] ien_q;
    wire logic wr_ien = wr_pend_q && hit_ien && run_mode;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            ien_q <= cbt_pkg::IRQ_EN_RESET;
        end else if (init_mode) begin
            ien_q <= cbt_pkg::IRQ_EN_RESET;
        end else if (wr_ien) begin
            ien_q <= {HWDATA[cbt_pkg::WAKE_BIT], HWDATA[cbt_pkg::CSC_BIT],
                HWDATA[cbt_pkg::OVR_BIT], HWDATA[cbt_pkg::RXF_BIT]};
        end
    end

    // read mux; reserved bits read zero
    wire logic [7:0] flg_rd = {flag_q[F_WAKE], flag_q[F_CSC], rx_shown_q, tx_shown_q, flag_q[F_OVR], flag_q[F_RXF]};
    wire logic [7:0] ien_rd = {ien_q[F_WAKE], ien_q[F_CSC], 4'h0, ien_q[F_OVR], ien_q[F_RXF]};
    wire logic [7:0] sts_rd = {6'h00, seg_bad, init_mode};
    wire logic [7:0] rd_mux = hit_btr ? btr_q : hit_flg ? flg_rd : hit_ien ? ien_rd : hit_sts ? sts_rd : 8'h00;

    wire logic [3:0] irq_on = flag_q & ien_q;
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            hrdata_q <= 32'h00000000;
            SEG_CFG_INVALID <= 1'b1;
            WAKEUP_IRQ <= 1'b0;
            ERROR_IRQ <= 1'b0;
            RX_IRQ <= 1'b0;
            FIFO_ADVANCE_OK <= 1'b1;
        end else begin
            if (ahb_q == cbt_pkg::AHB_READ_WAIT) begin
                hrdata_q <= {24'h000000, rd_mux};
            end
            SEG_CFG_INVALID <= seg_bad;
            WAKEUP_IRQ <= irq_on[F_WAKE];
            ERROR_IRQ <= irq_on[F_CSC] || irq_on[F_OVR];
            RX_IRQ <= irq_on[F_RXF];
            FIFO_ADVANCE_OK <= !flag_set[F_RXF] && !flag_q[F_RXF];
        end
    end

    assign HRDATA = hrdata_q;
    assign HREADYOUT = hready_q;
    assign HRESP = 1'b0;

    property p_btr_locked;
        @(posedge CLOCK) disable iff (!RST_B)
        (wr_pend_q && hit_btr && !init_mode) |=> $stable(btr_q);
    endproperty
    a_btr_locked: assert property (p_btr_locked) else $error("segment register written outside init");

    property p_clear_one;
        @(posedge CLOCK) disable iff (!RST_B)
        (wr_flg && HWDATA[cbt_pkg::OVR_BIT] && !OVERRUN_EVENT) |=> !flag_q[F_OVR];
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("overrun flag not cleared");

    property p_clear_zero;
        @(posedge CLOCK) disable iff (!RST_B)
        (wr_flg && flag_q[F_RXF] && !HWDATA[cbt_pkg::RXF_BIT] && !init_mode) |=> flag_q[F_RXF];
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("zero write cleared flag");

    property p_clear_blocked;
        @(posedge CLOCK) disable iff (!RST_B)
        (flag_set[F_WAKE] && !init_mode) |=> flag_q[F_WAKE];
    endproperty
    a_clear_blocked: assert property (p_clear_blocked) else $error("wake flag lost while active");

    sequence s_init_held;
        init_mode [*2];
    endsequence
    property p_init_reset;
        @(posedge CLOCK) disable iff (!RST_B)
        s_init_held |-> (flag_q == cbt_pkg::FLAGS_RESET && ien_q == cbt_pkg::IRQ_EN_RESET);
    endproperty
    a_init_reset: assert property (p_init_reset) else $error("flags not held in init");

    property p_irq_follow;
        @(posedge CLOCK) disable iff (!RST_B)
        (flag_q[F_RXF] && ien_q[F_RXF]) |=> RX_IRQ;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("receive interrupt missing");

    property p_status_change;
        @(posedge CLOCK) disable iff (!RST_B)
        (!flag_q[F_CSC] && shown_stale && !init_mode) |=> (flag_q[F_CSC] && rx_shown_q == $past(rx_live));
    endproperty
    a_status_change: assert property (p_status_change) else $error("status change not flagged");

    sequence s_csc_pending;
        flag_q[F_CSC] && !init_mode && !flag_clr[F_CSC];
    endsequence
    property p_frozen;
        @(posedge CLOCK) disable iff (!RST_B)
        s_csc_pending ##1 flag_q[F_CSC] |-> $stable(rx_shown_q) && $stable(tx_shown_q);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state fields moved while pending");

    property p_init_tracks;
        @(posedge CLOCK) disable iff (!RST_B)
        init_mode [*3] |-> (tx_shown_q == $past(tx_live));
    endproperty
    a_init_tracks: assert property (p_init_tracks) else $error("state fields stopped in init");

    property p_overrun;
        @(posedge CLOCK) disable iff (!RST_B)
        (OVERRUN_EVENT && !init_mode && ien_q[F_OVR] && !wr_ien) |=> flag_q[F_OVR] ##1 ERROR_IRQ;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not reported");

    property p_fifo_gate;
        @(posedge CLOCK) disable iff (!RST_B)
        flag_q[F_RXF] |=> !FIFO_ADVANCE_OK;
    endproperty
    a_fifo_gate: assert property (p_fifo_gate) else $error("fifo advance while full");

    property p_seg_bad;
        @(posedge CLOCK) disable iff (!RST_B)
        (seg1 < 4'h3 || seg2 == 3'h0) |=> SEG_CFG_INVALID;
    endproperty
    a_seg_bad: assert property (p_seg_bad) else $error("invalid segments not flagged");
endmodule : cbt_top

// >>> cbt_can_node.sv
`timescale 1ns/1ps
module cbt_can_node (
    // shared can line
    output logic can_rx
);
    // the line is driven from drv_q, which starts recessive (1)
    logic drv_q = 1'b1;
    assign can_rx = drv_q;
    task automatic level(input logic v);
        drv_q <= v;
    endtask : level
endmodule : cbt_can_node

// >>> test_can_bit_timing_rx_flags.sv
`timescale 1ns/1ps
module test_can_bit_timing_rx_flags;
    logic CLOCK = 0, RST_B = 0, HSEL = 0, HWRITE = 0, INIT_REQUEST = 0, INIT_ACK = 0;
    logic SLEEP_ACTIVE = 0, WAKEUP_ENABLE = 0, OVERRUN_EVENT = 0, RX_MSG_SHIFTED = 0;
    logic [31:0] HADDR = 0, HWDATA = 0, HRDATA;
    logic [1:0] HTRANS = 0;
    logic [5:0] PRESCALER = 0;
    logic [8:0] TX_ERROR_COUNT = 0;
    logic [7:0] RX_ERROR_COUNT = 0, r, v;
    logic HREADYOUT, HRESP, CAN_RX, TQ_TICK, RX_BIT, RX_BIT_VALID, SEG_CFG_INVALID;
    logic WAKEUP_IRQ, ERROR_IRQ, RX_IRQ, FIFO_ADVANCE_OK;
    int n_mismatch = 0, tests_run = 0, n, p, bt, te;
    localparam logic [11:0] FL = cbt_pkg::OFS_RX_FLAGS;
    localparam logic [11:0] BT = cbt_pkg::OFS_BIT_TIMING;
    always #(cbt_pkg::CLK_PERIOD_NS / 2) CLOCK = ~CLOCK;
    cbt_top i_cbt_top (.CLOCK(CLOCK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .INIT_REQUEST(INIT_REQUEST), .INIT_ACK(INIT_ACK), .SLEEP_ACTIVE(SLEEP_ACTIVE), .WAKEUP_ENABLE(WAKEUP_ENABLE),
        .PRESCALER(PRESCALER), .TX_ERROR_COUNT(TX_ERROR_COUNT), .RX_ERROR_COUNT(RX_ERROR_COUNT),
        .OVERRUN_EVENT(OVERRUN_EVENT), .RX_MSG_SHIFTED(RX_MSG_SHIFTED), .CAN_RX(CAN_RX), .TQ_TICK(TQ_TICK),
        .RX_BIT(RX_BIT), .RX_BIT_VALID(RX_BIT_VALID), .SEG_CFG_INVALID(SEG_CFG_INVALID), .WAKEUP_IRQ(WAKEUP_IRQ),
        .ERROR_IRQ(ERROR_IRQ), .RX_IRQ(RX_IRQ), .FIFO_ADVANCE_OK(FIFO_ADVANCE_OK));
    cbt_can_node i_cbt_can_node (.can_rx(CAN_RX));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    // state fields model: receive and transmit thresholds, bus-off forces both to 11
    function automatic logic [7:0] st_model(input int rx_error_count, input int tx_error_count);
        int rs, ts;
        rs = rx_error_count > 127 ? 2 : (rx_error_count > 96 ? 1 : 0);
        ts = tx_error_count > 127 ? 2 : (tx_error_count > 96 ? 1 : 0);
        if (tx_error_count > 255) begin
            rs = 3;
            ts = 3;
        end
        return 8'((rs << 4) | (ts << 2));
    endfunction : st_model
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        HSEL <= 1;
        HTRANS <= cbt_pkg::HTRANS_NONSEQ;
        HADDR <= {20'h0, a};
        HWRITE <= w;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HSEL <= 0;
        HTRANS <= 2'h0;
        HWDATA <= {24'h0, d};
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        r = HRDATA[7:0];
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        repeat (3) @(posedge CLOCK);
        bus(0, a, 8'h00);
        chk(r, e);
    endtask : rd
    task automatic mode(input logic m);
        INIT_REQUEST <= m;
        INIT_ACK <= m;
        repeat (2) @(posedge CLOCK);
    endtask : mode
    task automatic gap(ref logic sig, input int e);
        n = 0;
        @(posedge CLOCK iff sig === 1'b1);
        do begin
            @(posedge CLOCK);
            n++;
        end while (sig !== 1'b1);
        chk(8'(n), 8'(e));
    endtask : gap
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge CLOCK);
        n_mismatch++;
        final_report;
    end
    initial begin
        void'($urandom(35));
        repeat (2) @(posedge CLOCK);
        RST_B <= 1;
        rd(BT, cbt_pkg::BIT_TIMING_RESET);
        rd(12'h010, 8'h00);
        bus(1, BT, 8'h35);
        rd(BT, 8'h00);
        chk(SEG_CFG_INVALID, 1'b1);
        mode(1);
        // small prescaler keeps the bit time short, at most 100 clocks per bit
        p = $urandom % 4;
        v = {1'($urandom % 2), 3'(1 + $urandom % 7), 4'(3 + $urandom % 13)};
        PRESCALER <= 6'(p);
        bus(1, BT, v);
        rd(BT, v);
        chk(SEG_CFG_INVALID, 1'b0);
        mode(0);
        gap(TQ_TICK, p + 1);
        bt = (p + 1) * (3 + v[3:0] + v[6:4]);
        gap(RX_BIT_VALID, bt);
        SLEEP_ACTIVE <= 1;
        WAKEUP_ENABLE <= 1;
        i_cbt_can_node.level(0);
        repeat (2) @(posedge CLOCK iff RX_BIT_VALID);
        chk(RX_BIT, 1'b0);
        i_cbt_can_node.level(1);
        SLEEP_ACTIVE <= 0;
        rd(FL, 8'h80);
        bus(1, cbt_pkg::OFS_RX_IRQ_EN, 8'hC3);
        rd(cbt_pkg::OFS_RX_IRQ_EN, 8'hC3);
        chk(WAKEUP_IRQ, 1'b1);
        bus(1, FL, 8'h80);
        rd(FL, 8'h00);
        OVERRUN_EVENT <= 1;
        RX_MSG_SHIFTED <= 1;
        @(posedge CLOCK);
        RX_MSG_SHIFTED <= 0;
        rd(FL, 8'h03);
        chk({ERROR_IRQ, RX_IRQ, FIFO_ADVANCE_OK}, 3'b110);
        bus(1, FL, 8'h03);
        rd(FL, 8'h02);
        OVERRUN_EVENT <= 0;
        bus(1, FL, 8'h00);
        rd(FL, 8'h02);
        bus(1, FL, 8'hFF);
        rd(FL, 8'h00);
        RX_ERROR_COUNT <= 97;
        rd(FL, 8'h40 | st_model(97, 0));
        RX_ERROR_COUNT <= 128;
        TX_ERROR_COUNT <= 256;
        rd(FL, 8'h40 | st_model(97, 0));
        bus(1, FL, 8'h40);
        rd(FL, 8'h40 | st_model(128, 256));
        mode(1);
        // transmit count in the passive band, below bus-off
        te = 128 + $urandom % 128;
        TX_ERROR_COUNT <= 9'(te);
        rd(FL, st_model(128, te));
        rd(cbt_pkg::OFS_RX_IRQ_EN, 8'h00);
        rd(cbt_pkg::OFS_MODE_STATUS, 8'h01);
        // the other sampling mode, so both single and majority decisions are exercised
        bus(1, BT, v ^ 8'h80);
        rd(BT, v ^ 8'h80);
        mode(0);
        i_cbt_can_node.level(0);
        repeat (2) @(posedge CLOCK iff RX_BIT_VALID);
        chk(RX_BIT, 1'b0);
        i_cbt_can_node.level(1);
        repeat (2) @(posedge CLOCK iff RX_BIT_VALID);
        chk(RX_BIT, 1'b1);
        chk(HRESP, 1'b0);
        final_report;
    end
endmodule : test_can_bit_timing_rx_flags
